// file: hw/cpl_pkg.sv
// package for the converter protection limit register bank:
// command codes, limit table, reset values, status bit positions and carrier types.
// assumes the linear formats of the management bus with exponents fixed per command.
package cpl_pkg;

	// command codes
	localparam logic [7:0] CODE_VIN_ON = 8'h35;
	localparam logic [7:0] CODE_VIN_OFF = 8'h36;
	localparam logic [7:0] CODE_VOUT_OV_FAULT = 8'h40;
	localparam logic [7:0] CODE_VOUT_OV_ACTION = 8'h41;
	localparam logic [7:0] CODE_VOUT_OV_WARN = 8'h42;
	localparam logic [7:0] CODE_IOUT_OC_FAULT = 8'h46;
	localparam logic [7:0] CODE_IOUT_OC_ACTION = 8'h47;
	localparam logic [7:0] CODE_IOUT_OC_WARN = 8'h4a;
	localparam logic [7:0] CODE_OT_FAULT = 8'h4f;
	localparam logic [7:0] CODE_OT_ACTION = 8'h50;
	localparam logic [7:0] CODE_OT_WARN = 8'h51;
	localparam logic [7:0] CODE_VIN_OV_FAULT = 8'h55;
	localparam logic [7:0] CODE_VIN_OV_ACTION = 8'h56;
	localparam logic [7:0] CODE_GOOD_ON = 8'h5e;
	localparam logic [7:0] CODE_GOOD_OFF = 8'h5f;
	localparam logic [7:0] CODE_START_DELAY = 8'h60;
	localparam logic [7:0] CODE_RAMP_TIME = 8'h61;
	localparam logic [7:0] CODE_STATUS_WORD = 8'h79;
	localparam logic [7:0] CODE_STATUS_VOUT = 8'h7a;
	localparam logic [7:0] CODE_OUTPUT_CURRENT_STATUS = 8'h7b;

	// fixed fault action bytes
	localparam logic [7:0] VOUT_OV_ACTION_VAL = 8'hb8;
	localparam logic [7:0] IOUT_OC_ACTION_VAL = 8'hf8;
	localparam logic [7:0] OT_ACTION_VAL = 8'h80;
	localparam logic [7:0] VIN_OV_ACTION_VAL = 8'hc0;

	// index of each read/write limit word inside the limit array
	typedef enum logic [3:0] {
		L_VIN_ON, L_VIN_OFF, L_VOUT_OV_F, L_VOUT_OV_W, L_IOUT_OC_F, L_IOUT_OC_W,
		L_OT_F, L_OT_W, L_VIN_OV_F, L_GOOD_ON, L_GOOD_OFF, L_DELAY, L_RAMP
	} cpl_lim_t;
	localparam int LIM_COUNT = 13;

	// linear exponent fields
	localparam logic [4:0] EXP_VIN = 5'h1d;
	localparam logic [4:0] EXP_IOUT = 5'h1c;
	localparam logic [4:0] EXP_TEMP = 5'h1e;
	localparam logic [4:0] EXP_TIME = 5'h1f;

	// status bit positions
	localparam int SV_OV_FAULT = 7;
	localparam int SV_OV_WARN = 6;
	localparam int SI_OC_FAULT = 7;
	localparam int SI_OC_WARN = 5;
	localparam int SW_GOOD = 11;
	localparam int SW_VOUT = 15;
	localparam int SW_IOUT = 14;
	localparam int SW_INPUT = 13;
	localparam int SW_OFF = 6;
	localparam int SW_VOUT_OV = 5;
	localparam int SW_IOUT_OC = 4;
	localparam int SW_VIN_UV = 3;
	localparam int SW_TEMP = 2;
	localparam int SW_CML = 1;

	// time base: one count of the delay and ramp words is half a millisecond
	localparam int CLK_PERIOD_NS = 50;
	localparam int TIME_UNIT_NS = 500000;
	localparam int TIME_UNIT_CYCLES = TIME_UNIT_NS / CLK_PERIOD_NS;

	// measured quantities, each at the fixed exponent of its limit words
	typedef struct packed {
		logic [15:0] vin;
		logic [15:0] vout;
		logic [15:0] iout;
		logic [15:0] temp;
	} cpl_meas_t;

	// one command request from the bus transaction layer
	typedef struct packed {
		logic [7:0] code;
		logic wr;
		logic rd;
		logic [15:0] wdata;
	} cpl_cmd_t;

	// value after reset of each limit word
	function automatic logic [15:0] lim_reset(input cpl_lim_t i);
		case (i)
			L_VIN_ON: lim_reset = 16'he918;
			L_VIN_OFF: lim_reset = 16'he908;
			L_VOUT_OV_F: lim_reset = 16'hf000;
			L_VOUT_OV_W: lim_reset = 16'hf000;
			L_IOUT_OC_F: lim_reset = 16'he200;
			L_IOUT_OC_W: lim_reset = 16'he1b0;
			L_OT_F: lim_reset = 16'hf1f4;
			L_OT_W: lim_reset = 16'hf190;
			L_VIN_OV_F: lim_reset = 16'heb70;
			L_GOOD_ON: lim_reset = 16'hb000;
			L_GOOD_OFF: lim_reset = 16'h9000;
			L_DELAY: lim_reset = 16'hf828;
			L_RAMP: lim_reset = 16'hf828;
			default: lim_reset = 16'h0000;
		endcase
	endfunction

	// lower and upper accepted value; mantissa only for the 11-bit words
	function automatic logic [31:0] lim_range(input cpl_lim_t i);
		case (i)
			L_VIN_ON: lim_range = {16'h0108, 16'h0120};
			L_VIN_OFF: lim_range = {16'h00f8, 16'h0110};
			L_VOUT_OV_F, L_VOUT_OV_W: lim_range = {16'hb000, 16'hffff};
			L_IOUT_OC_F, L_IOUT_OC_W: lim_range = {16'h0140, 16'h0230};
			L_OT_F, L_OT_W: lim_range = {16'h0064, 16'h0230};
			L_VIN_OV_F: lim_range = {16'h0180, 16'h0370};
			L_GOOD_ON, L_GOOD_OFF: lim_range = {16'h8000, 16'hd333};
			L_DELAY: lim_range = {16'h000a, 16'h03e8};
			L_RAMP: lim_range = {16'h001e, 16'h03e8};
			default: lim_range = 32'h0000_0000;
		endcase
	endfunction

endpackage

// file: hw/cpl_limit_bank.sv
// converter protection limit register bank: the command-addressed limit words, fault
// action bytes, sticky status bytes, power-good hysteresis and the start sequencer.
// assumes a transaction layer on CORE_CLK that delivers one decoded command at a time,
// and measurement words from the converter's sampling path on the same clock.
//
// Notes on behaviour
// [R1] input turn-on threshold word at 0x35, exponent -3, default 35 V, accepts 33..36 V
// [R2] input turn-off threshold word at 0x36, exponent -3, default 33 V, accepts 31..34 V
// [R3] host should keep the turn-on threshold above the turn-off threshold
// [R4] output overvoltage fault limit at 0x40, exponent -12, default 15 V, 11..16 V
// [R5] host keeps overvoltage fault limit above nominal output and warning limit
// [R6] output overvoltage fault action is read-only byte 0x41, value 0xb8
// [R7] output overvoltage warning limit at 0x42, exponent -12, default 15 V
// [R8] output overcurrent fault limit at 0x46, exponent -4, default 32 A, 20..35 A
// [R9] output overcurrent fault action is read-only byte 0x47, value 0xf8
// [R10] output overcurrent warning limit at 0x4a, exponent -4, default 27 A
// [R11] over-temperature fault limit at 0x4f, exponent -2, default 125 C
// [R12] over-temperature fault action is read-only byte 0x50, value 0x80
// [R13] temperature warning limit at 0x51, exponent -2, default 100 C, 25..140 C
// [R14] input overvoltage fault limit at 0x55, exponent -3, default 110 V, 48..110 V
// [R15] input overvoltage fault action is read-only byte 0x56, value 0xc0
// [R16] power-good bit 11 of the status word set when output reaches level 0x5e
// [R17] power-good bit cleared when output falls to level 0x5f, default 9 V
// [R18] wait programmed delay at 0x60, half-ms units, before starting the output rise
// [R19] ramp output over programmed rise time at 0x61, half-ms units
// [R20] read-only summary status word at 0x79
// [R21] output-voltage status byte at 0x7a, readable and writable
// [R22] output-current status byte at 0x7b, readable and writable
// [R23] output-voltage words are 16-bit unsigned mantissas at exponent -12
// [R24] other words: 11-bit signed mantissa low, 5-bit signed exponent high
// [R25] crossing a warning or fault limit sets a sticky status bit until cleared
`timescale 1ns/1ps

module cpl_limit_bank #(
	parameter int TIME_UNIT_CYCLES = cpl_pkg::TIME_UNIT_CYCLES
) (
	// clock and reset
	input wire logic CORE_CLK,
	input wire logic RST_N,
	// command port from the bus transaction layer
	input wire cpl_pkg::cpl_cmd_t CMD,
	input wire logic CLEAR_STATUS,
	output logic RSP_VALID,
	output logic RSP_ERR,
	output logic [15:0] RSP_RDATA,
	// measurements and on/off pin
	input wire cpl_pkg::cpl_meas_t MEAS,
	input wire logic ENABLE_PIN,
	// converter control and status
	output logic OUTPUT_GOOD,
	output logic RAMP_ACTIVE,
	output logic OUTPUT_ON,
	output logic [15:0] STATUS_WORD_OUT
);

	////////////////////////////////////////////////////////////////////////////////
	// helpers

	// maps a command code to a limit word index; bit 4 says the code is a limit word
	function automatic logic [4:0] code_to_lim(input logic [7:0] code);
		case (code)
			cpl_pkg::CODE_VIN_ON: code_to_lim = {1'b1, cpl_pkg::L_VIN_ON};
			cpl_pkg::CODE_VIN_OFF: code_to_lim = {1'b1, cpl_pkg::L_VIN_OFF};
			cpl_pkg::CODE_VOUT_OV_FAULT: code_to_lim = {1'b1, cpl_pkg::L_VOUT_OV_F};
			cpl_pkg::CODE_VOUT_OV_WARN: code_to_lim = {1'b1, cpl_pkg::L_VOUT_OV_W};
			cpl_pkg::CODE_IOUT_OC_FAULT: code_to_lim = {1'b1, cpl_pkg::L_IOUT_OC_F};
			cpl_pkg::CODE_IOUT_OC_WARN: code_to_lim = {1'b1, cpl_pkg::L_IOUT_OC_W};
			cpl_pkg::CODE_OT_FAULT: code_to_lim = {1'b1, cpl_pkg::L_OT_F};
			cpl_pkg::CODE_OT_WARN: code_to_lim = {1'b1, cpl_pkg::L_OT_W};
			cpl_pkg::CODE_VIN_OV_FAULT: code_to_lim = {1'b1, cpl_pkg::L_VIN_OV_F};
			cpl_pkg::CODE_GOOD_ON: code_to_lim = {1'b1, cpl_pkg::L_GOOD_ON};
			cpl_pkg::CODE_GOOD_OFF: code_to_lim = {1'b1, cpl_pkg::L_GOOD_OFF};
			cpl_pkg::CODE_START_DELAY: code_to_lim = {1'b1, cpl_pkg::L_DELAY};
			cpl_pkg::CODE_RAMP_TIME: code_to_lim = {1'b1, cpl_pkg::L_RAMP};
			default: code_to_lim = 5'h00;
		endcase
	endfunction

	// true for the output-voltage words, which carry no exponent field
	function automatic logic is_vout_word(input cpl_pkg::cpl_lim_t i);
		is_vout_word = (i == cpl_pkg::L_VOUT_OV_F) || (i == cpl_pkg::L_VOUT_OV_W) ||
			(i == cpl_pkg::L_GOOD_ON) || (i == cpl_pkg::L_GOOD_OFF);
	endfunction

	// exponent field that an 11-bit word must carry
	function automatic logic [4:0] lim_exp(input cpl_pkg::cpl_lim_t i);
		case (i)
			cpl_pkg::L_VIN_ON, cpl_pkg::L_VIN_OFF, cpl_pkg::L_VIN_OV_F:
				lim_exp = cpl_pkg::EXP_VIN;
			cpl_pkg::L_IOUT_OC_F, cpl_pkg::L_IOUT_OC_W: lim_exp = cpl_pkg::EXP_IOUT;
			cpl_pkg::L_OT_F, cpl_pkg::L_OT_W: lim_exp = cpl_pkg::EXP_TEMP;
			default: lim_exp = cpl_pkg::EXP_TIME;
		endcase
	endfunction

	// range and format check of a written word; the exponent cannot be altered
	function automatic logic write_ok(input cpl_pkg::cpl_lim_t i, input logic [15:0] w);
		logic [31:0] r;
		r = cpl_pkg::lim_range(i);
		if (is_vout_word(i)) begin
			write_ok = (w >= r[31:16]) && (w <= r[15:0]); // R23
		end else begin
			write_ok = (w[15:11] == lim_exp(i)) && (w[10] == 1'b0) &&
				({5'h00, w[10:0]} >= r[31:16]) && ({5'h00, w[10:0]} <= r[15:0]); // R24
		end
	endfunction

	// signed compare a >= b of two 11-bit mantissas sharing one exponent
	function automatic logic mant_ge(input logic [15:0] a, input logic [15:0] b);
		mant_ge = $signed(a[10:0]) >= $signed(b[10:0]); // R24
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// request decode

	logic [4:0] lim_hit;
	cpl_pkg::cpl_lim_t lim_idx;
	logic lim_wr_ok;
	logic stat_wr;
	logic cmd_known;

	assign lim_hit = code_to_lim(CMD.code);
	assign lim_idx = cpl_pkg::cpl_lim_t'(lim_hit[3:0]);
	assign lim_wr_ok = CMD.wr && lim_hit[4] && write_ok(lim_idx, CMD.wdata);
	assign stat_wr = CMD.wr && ((CMD.code == cpl_pkg::CODE_STATUS_VOUT) ||
		(CMD.code == cpl_pkg::CODE_OUTPUT_CURRENT_STATUS));

	// codes that exist for a read; fault action bytes and the status word only read
	always_comb begin
		case (CMD.code)
			cpl_pkg::CODE_VOUT_OV_ACTION, cpl_pkg::CODE_IOUT_OC_ACTION,
			cpl_pkg::CODE_OT_ACTION, cpl_pkg::CODE_VIN_OV_ACTION,
			cpl_pkg::CODE_STATUS_WORD, cpl_pkg::CODE_STATUS_VOUT,
			cpl_pkg::CODE_OUTPUT_CURRENT_STATUS: cmd_known = 1'b1;
			default: cmd_known = lim_hit[4];
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// limit words

	logic [15:0] lim_q [0:cpl_pkg::LIM_COUNT-1];

	// an out-of-range or wrongly scaled write leaves the old value in place
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			for (int i = 0; i < cpl_pkg::LIM_COUNT; i++) begin
				lim_q[i] <= cpl_pkg::lim_reset(cpl_pkg::cpl_lim_t'(i[3:0])); // R1 R2 R4 R7
			end
		end else if (lim_wr_ok) begin
			lim_q[lim_idx] <= CMD.wdata; // R1 R2 R4 R7 R8 R10 R11 R13 R14 R16 R17 R18 R19
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// live comparisons against the limits

	logic vout_ov_fault;
	logic vout_ov_warn;
	logic iout_oc_fault;
	logic iout_oc_warn;
	logic ot_fault;
	logic ot_warn;
	logic vin_ov_fault;
	logic vin_above_on;
	logic vin_below_off;

	assign vout_ov_fault = MEAS.vout >= lim_q[cpl_pkg::L_VOUT_OV_F]; // R25
	assign vout_ov_warn = MEAS.vout >= lim_q[cpl_pkg::L_VOUT_OV_W]; // R25
	assign iout_oc_fault = mant_ge(MEAS.iout, lim_q[cpl_pkg::L_IOUT_OC_F]); // R25
	assign iout_oc_warn = mant_ge(MEAS.iout, lim_q[cpl_pkg::L_IOUT_OC_W]); // R25
	assign ot_fault = mant_ge(MEAS.temp, lim_q[cpl_pkg::L_OT_F]); // R25
	assign ot_warn = mant_ge(MEAS.temp, lim_q[cpl_pkg::L_OT_W]); // R25
	assign vin_ov_fault = mant_ge(MEAS.vin, lim_q[cpl_pkg::L_VIN_OV_F]); // R25
	assign vin_above_on = mant_ge(MEAS.vin, lim_q[cpl_pkg::L_VIN_ON]);
	assign vin_below_off = mant_ge(lim_q[cpl_pkg::L_VIN_OFF], MEAS.vin);

	////////////////////////////////////////////////////////////////////////////////
	// undervoltage lockout and power-good hysteresis

	logic vin_ok_q;
	logic good_q;

	// the gap between the two thresholds is the lockout hysteresis
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			vin_ok_q <= 1'b0;
		end else if (vin_below_off) begin
			vin_ok_q <= 1'b0; // R2
		end else if (vin_above_on) begin
			vin_ok_q <= 1'b1; // R1
		end
	end

	// negate wins when the levels overlap, so a misprogrammed pair cannot chatter high
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			good_q <= 1'b0;
		end else if (MEAS.vout <= lim_q[cpl_pkg::L_GOOD_OFF]) begin
			good_q <= 1'b0; // R17
		end else if (MEAS.vout >= lim_q[cpl_pkg::L_GOOD_ON]) begin
			good_q <= 1'b1; // R16
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// sticky status bits

	logic [7:0] stat_vout_q;
	logic [7:0] stat_iout_q;
	logic ot_fault_q;
	logic ot_warn_q;
	logic vin_ov_q;
	logic vin_uv_q;
	logic cml_q;
	logic [7:0] vout_set;
	logic [7:0] iout_set;
	logic [7:0] vout_clr;
	logic [7:0] iout_clr;

	always_comb begin
		vout_set = 8'h00;
		iout_set = 8'h00;
		vout_set[cpl_pkg::SV_OV_FAULT] = vout_ov_fault;
		vout_set[cpl_pkg::SV_OV_WARN] = vout_ov_warn;
		iout_set[cpl_pkg::SI_OC_FAULT] = iout_oc_fault;
		iout_set[cpl_pkg::SI_OC_WARN] = iout_oc_warn;
		vout_clr = 8'h00;
		iout_clr = 8'h00;
		if (CLEAR_STATUS) begin
			vout_clr = 8'hff;
			iout_clr = 8'hff;
		end else if (stat_wr && (CMD.code == cpl_pkg::CODE_STATUS_VOUT)) begin
			vout_clr = CMD.wdata[7:0];
		end else if (stat_wr) begin
			iout_clr = CMD.wdata[7:0];
		end
	end

	// writing a one clears a bit; a condition present in that cycle sets it again
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			stat_vout_q <= 8'h00;
			stat_iout_q <= 8'h00;
		end else begin
			stat_vout_q <= (stat_vout_q & ~vout_clr) | vout_set; // R21 R25
			stat_iout_q <= (stat_iout_q & ~iout_clr) | iout_set; // R22 R25
		end
	end

	// input, temperature and command-error flags clear only on the clear strobe
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			ot_fault_q <= 1'b0;
			ot_warn_q <= 1'b0;
			vin_ov_q <= 1'b0;
			vin_uv_q <= 1'b0;
			cml_q <= 1'b0;
		end else begin
			ot_fault_q <= (ot_fault_q & ~CLEAR_STATUS) | ot_fault; // R25
			ot_warn_q <= (ot_warn_q & ~CLEAR_STATUS) | ot_warn; // R25
			vin_ov_q <= (vin_ov_q & ~CLEAR_STATUS) | vin_ov_fault; // R25
			vin_uv_q <= (vin_uv_q & ~CLEAR_STATUS) | (OUTPUT_ON & vin_below_off);
			cml_q <= (cml_q & ~CLEAR_STATUS) | (RSP_VALID & RSP_ERR);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// start sequencer

	typedef enum logic [1:0] {SEQ_OFF, SEQ_DELAY, SEQ_RISE, SEQ_ON} cpl_seq_t;

	cpl_seq_t seq_q;
	logic en_meta_q;
	logic en_q;
	logic [15:0] unit_cnt_q;
	logic [10:0] time_cnt_q;
	logic unit_tick;
	logic shut;
	logic start_ok;

	// the on/off pin is asynchronous to the core clock
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			en_meta_q <= 1'b0;
			en_q <= 1'b0;
		end else begin
			en_meta_q <= ENABLE_PIN;
			en_q <= en_meta_q;
		end
	end

	// every fault action shuts the unit down; the restart comes once the fault is gone
	assign shut = (vout_ov_fault && (cpl_pkg::VOUT_OV_ACTION_VAL[7:6] != 2'b00)) ||
		(iout_oc_fault && (cpl_pkg::IOUT_OC_ACTION_VAL[7:6] != 2'b00)) ||
		(ot_fault && (cpl_pkg::OT_ACTION_VAL[7:6] != 2'b00)) ||
		(vin_ov_fault && (cpl_pkg::VIN_OV_ACTION_VAL[7:6] != 2'b00));
	assign start_ok = en_q && vin_ok_q && !shut;
	assign unit_tick = unit_cnt_q == 16'(TIME_UNIT_CYCLES - 1);

	// half-millisecond prescaler, restarted at each phase so a phase is never short
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			unit_cnt_q <= 16'h0000;
		end else if (seq_q == SEQ_OFF || seq_q == SEQ_ON || unit_tick) begin
			unit_cnt_q <= 16'h0000;
		end else begin
			unit_cnt_q <= unit_cnt_q + 16'h0001;
		end
	end

	// delay then ramp, each counted in half-millisecond units of its mantissa
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			seq_q <= SEQ_OFF;
			time_cnt_q <= 11'h000;
		end else if (!start_ok) begin
			seq_q <= SEQ_OFF;
			time_cnt_q <= 11'h000;
		end else begin
			case (seq_q)
				SEQ_OFF: begin
					seq_q <= SEQ_DELAY;
					time_cnt_q <= 11'h000;
				end
				SEQ_DELAY: begin
					if (unit_tick && time_cnt_q + 11'h001 >= lim_q[cpl_pkg::L_DELAY][10:0]) begin
						seq_q <= SEQ_RISE; // R18
						time_cnt_q <= 11'h000;
					end else if (unit_tick) begin
						time_cnt_q <= time_cnt_q + 11'h001;
					end
				end
				SEQ_RISE: begin
					if (unit_tick && time_cnt_q + 11'h001 >= lim_q[cpl_pkg::L_RAMP][10:0]) begin
						seq_q <= SEQ_ON; // R19
						time_cnt_q <= 11'h000;
					end else if (unit_tick) begin
						time_cnt_q <= time_cnt_q + 11'h001;
					end
				end
				SEQ_ON: seq_q <= SEQ_ON;
				default: seq_q <= SEQ_OFF;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// status word and read answers

	logic [15:0] status_word;

	always_comb begin
		status_word = 16'h0000;
		status_word[cpl_pkg::SW_GOOD] = good_q; // R16 R17
		status_word[cpl_pkg::SW_VOUT] = |stat_vout_q; // R20
		status_word[cpl_pkg::SW_IOUT] = |stat_iout_q; // R20
		status_word[cpl_pkg::SW_INPUT] = vin_ov_q | vin_uv_q; // R20
		status_word[cpl_pkg::SW_OFF] = seq_q != SEQ_ON; // R20
		status_word[cpl_pkg::SW_VOUT_OV] = stat_vout_q[cpl_pkg::SV_OV_FAULT]; // R20
		status_word[cpl_pkg::SW_IOUT_OC] = stat_iout_q[cpl_pkg::SI_OC_FAULT]; // R20
		status_word[cpl_pkg::SW_VIN_UV] = vin_uv_q; // R20
		status_word[cpl_pkg::SW_TEMP] = ot_fault_q | ot_warn_q; // R20
		status_word[cpl_pkg::SW_CML] = cml_q; // R20
	end

	// every request is answered on the next edge; refused writes and unknown codes err
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			RSP_VALID <= 1'b0;
			RSP_ERR <= 1'b0;
			RSP_RDATA <= 16'h0000;
		end else begin
			RSP_VALID <= CMD.wr | CMD.rd;
			RSP_ERR <= (CMD.rd && !cmd_known) || (CMD.wr && !lim_wr_ok && !stat_wr);
			if (CMD.rd) begin
				case (CMD.code)
					cpl_pkg::CODE_VOUT_OV_ACTION:
						RSP_RDATA <= {8'h00, cpl_pkg::VOUT_OV_ACTION_VAL}; // R6
					cpl_pkg::CODE_IOUT_OC_ACTION:
						RSP_RDATA <= {8'h00, cpl_pkg::IOUT_OC_ACTION_VAL}; // R9
					cpl_pkg::CODE_OT_ACTION: RSP_RDATA <= {8'h00, cpl_pkg::OT_ACTION_VAL}; // R12
					cpl_pkg::CODE_VIN_OV_ACTION:
						RSP_RDATA <= {8'h00, cpl_pkg::VIN_OV_ACTION_VAL}; // R15
					cpl_pkg::CODE_STATUS_WORD: RSP_RDATA <= status_word; // R20
					cpl_pkg::CODE_STATUS_VOUT: RSP_RDATA <= {8'h00, stat_vout_q}; // R21
					cpl_pkg::CODE_OUTPUT_CURRENT_STATUS: RSP_RDATA <= {8'h00, stat_iout_q}; // R22
					default: RSP_RDATA <= lim_hit[4] ? lim_q[lim_idx] : 16'h0000;
				endcase
			end
		end
	end

	// converter-facing outputs, all from flip-flops
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			OUTPUT_GOOD <= 1'b0;
			RAMP_ACTIVE <= 1'b0;
			OUTPUT_ON <= 1'b0;
			STATUS_WORD_OUT <= 16'h0000;
		end else begin
			OUTPUT_GOOD <= good_q;
			RAMP_ACTIVE <= seq_q == SEQ_RISE; // R19
			OUTPUT_ON <= seq_q == SEQ_RISE || seq_q == SEQ_ON;
			STATUS_WORD_OUT <= status_word;
		end
	end

endmodule

// file: bench/cpl_host_model.sv
// host master model: issues one command at a time on the command port.
// assumes responses are registered on the taking edge, one cycle after the command is driven.
`timescale 1ns/1ps
module cpl_host_model (
	// clock
	input wire logic core_clk,
	// command port
	output cpl_pkg::cpl_cmd_t cmd,
	input wire logic rsp_valid,
	input wire logic rsp_err,
	input wire logic [15:0] rsp_rdata
);
	////////////////////////
	initial cmd = '0;

	// whole word per request; released lines show the inverse so stale data cannot match
	task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
		output logic [17:0] r);
		@(posedge core_clk);
		#1;
		cmd = '{code: c, wr: w, rd: !w, wdata: d};
		@(posedge core_clk);
		#1;
		r = {rsp_valid, rsp_err, rsp_rdata};
		cmd = '{code: ~c, wr: 1'b0, rd: 1'b0, wdata: ~d};
	endtask
endmodule

// file: bench/cpl_limit_bank_checker.sv
// checker for the limit bank: answer timing, refusals, status summary and start order.
// assumes it is bound to cpl_limit_bank and sees only its ports.
`timescale 1ns/1ps
module cpl_limit_bank_checker #(
	parameter int TIME_UNIT_CYCLES = 4
) (
	// clock and reset
	input wire logic CORE_CLK,
	input wire logic RST_N,
	// command port
	input wire cpl_pkg::cpl_cmd_t CMD,
	input wire logic CLEAR_STATUS,
	input wire logic RSP_VALID,
	input wire logic RSP_ERR,
	input wire logic [15:0] RSP_RDATA,
	// converter side
	input wire cpl_pkg::cpl_meas_t MEAS,
	input wire logic ENABLE_PIN,
	input wire logic OUTPUT_GOOD,
	input wire logic RAMP_ACTIVE,
	input wire logic OUTPUT_ON,
	input wire logic [15:0] STATUS_WORD_OUT
);
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RST_N);
	////////////////////////
	// each request answered exactly one cycle later, and only then
	a_rsp_one_cycle: assert property ((CMD.wr || CMD.rd) |=> RSP_VALID)
		else $error("request not answered after one cycle");
	a_rsp_no_extra: assert property (!(CMD.wr || CMD.rd) |=> !RSP_VALID)
		else $error("answer without request");
	// fixed action bytes and the summary word refuse writes
	a_action_ro: assert property (CMD.wr && CMD.code inside {8'h41, 8'h47, 8'h50, 8'h56} |=> RSP_ERR)
		else $error("write to action byte accepted");
	a_summary_ro: assert property (CMD.wr && CMD.code == 8'h79 |=> RSP_ERR)
		else $error("write to status word accepted");
	a_action_value: assert property (CMD.rd && CMD.code == 8'h47 |=> RSP_RDATA == 16'h00f8)
		else $error("wrong overcurrent action byte");
	// the input turn-on word at 0x35 must carry exponent -3
	a_exp_refused: assert property (CMD.wr && CMD.code == 8'h35 && CMD.wdata[15:11] != 5'h1d |=> RSP_ERR)
		else $error("wrong exponent accepted");
	// a refused request raises the command fault bit soon after
	a_err_flags_cml: assert property (RSP_VALID && RSP_ERR && !CLEAR_STATUS ##1 !CLEAR_STATUS |-> ##[0:1] STATUS_WORD_OUT[1])
		else $error("error not flagged in status word");
	// summary bits follow the fault bits of the status bytes
	a_vout_summary: assert property (STATUS_WORD_OUT[5] |-> STATUS_WORD_OUT[15])
		else $error("voltage fault not summarised");
	a_iout_summary: assert property (STATUS_WORD_OUT[4] |-> STATUS_WORD_OUT[14])
		else $error("current fault not summarised");
	// output starts with its rise, which lasts at least 8 cycles while the output stays on
	a_on_starts_rise: assert property ($rose(OUTPUT_ON) |-> RAMP_ACTIVE)
		else $error("output on without rise phase");
	a_rise_holds: assert property ($rose(RAMP_ACTIVE) ##0 OUTPUT_ON[*8] |-> RAMP_ACTIVE)
		else $error("rise phase too short");
	a_good_from_bit: assert property ($rose(OUTPUT_GOOD) |-> STATUS_WORD_OUT[11] || $past(STATUS_WORD_OUT[11]))
		else $error("power good without status bit");
	c_refused: cover property (RSP_VALID && RSP_ERR);
	c_rise_done: cover property ($fell(RAMP_ACTIVE) && OUTPUT_ON);
	c_good: cover property ($rose(OUTPUT_GOOD));
endmodule

// file: bench/tb.sv
// testbench for the limit bank: defaults, range refusals, status bytes, start sequence.
// assumes the host model drives commands; the time unit is shortened to 4 cycles.
`timescale 1ns/1ps
module tb;
	localparam int TU = 4;
	logic core_clk, rst_n, clear_status, enable_pin;
	logic rsp_valid, rsp_err, output_good, ramp_active, output_on;
	logic [15:0] rsp_rdata, status_word;
	logic [17:0] r;
	cpl_pkg::cpl_cmd_t cmd;
	cpl_pkg::cpl_meas_t meas;
	int error_cnt = 0;
	int samples_checked = 0;
	int n;
	// reset values of limit words, then action bytes
	logic [7:0] codes [17] = '{8'h35, 8'h36, 8'h40, 8'h42, 8'h46, 8'h4a, 8'h4f, 8'h51,
		8'h55, 8'h5e, 8'h5f, 8'h60, 8'h61, 8'h41, 8'h47, 8'h50, 8'h56};
	logic [15:0] dflt [17] = '{16'he918, 16'he908, 16'hf000, 16'hf000, 16'he200, 16'he1b0,
		16'hf1f4, 16'hf190, 16'heb70, 16'hb000, 16'h9000, 16'hf828, 16'hf828, 16'h00b8,
		16'h00f8, 16'h0080, 16'h00c0};
	// code, data, refused, value read back; turn-on kept above turn-off
	logic [47:0] wtab [18] = '{48'h35e90701e918, 48'h35f11801e918, 48'h35e92000e920,
		48'h36e8f701e908, 48'h36e91000e910, 48'h40afff01f000, 48'h40ffff00ffff,
		48'h5e7fff01b000, 48'h46e13f01e200, 48'h46e23000e230, 48'h4ae1c000e1c0,
		48'h51f06301f190, 48'h51f1e000f1e0, 48'h55e97f01eb70, 48'h60f80901f828,
		48'h61f81e00f81e, 48'h4100000100b8, 48'h5600000100c0};
	////////////////////////
	cpl_limit_bank #(.TIME_UNIT_CYCLES(TU)) i_dut (.CORE_CLK(core_clk), .RST_N(rst_n),
		.CMD(cmd), .CLEAR_STATUS(clear_status), .RSP_VALID(rsp_valid), .RSP_ERR(rsp_err),
		.RSP_RDATA(rsp_rdata), .MEAS(meas), .ENABLE_PIN(enable_pin),
		.OUTPUT_GOOD(output_good), .RAMP_ACTIVE(ramp_active), .OUTPUT_ON(output_on),
		.STATUS_WORD_OUT(status_word));
	cpl_host_model i_host (.core_clk(core_clk), .cmd(cmd), .rsp_valid(rsp_valid),
		.rsp_err(rsp_err), .rsp_rdata(rsp_rdata));
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	task automatic tick(input int k);
		repeat (k) @(posedge core_clk);
		#1;
	endtask
	task automatic check(input logic [17:0] seen, input logic [17:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic rd(input logic [7:0] c, input logic e, input logic [15:0] x);
		i_host.xfer(1'b0, c, 16'h0000, r);
		check(r, {1'b1, e, x});
	endtask
	task automatic wr(input logic [7:0] c, input logic [15:0] d, input logic e);
		i_host.xfer(1'b1, c, d, r);
		check({r[17:16], 16'h0000}, {1'b1, e, 16'h0000});
	endtask
	task automatic pulse_clear();
		clear_status = 1'b1;
		tick(1);
		clear_status = 1'b0;
	endtask
	task automatic results();
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// hang guard
	initial begin
		repeat (20000) @(posedge core_clk);
		error_cnt++;
		results();
	end
	initial begin
		rst_n = 1'b0;
		clear_status = 1'b0;
		enable_pin = 1'b0;
		meas = '{vin: 16'he980, vout: 16'h0000, iout: 16'he000, temp: 16'hf064};
		tick(10);
		rst_n = 1'b1;
		for (n = 0; n < 17; n++) rd(codes[n], 1'b0, dflt[n]);
		for (n = 0; n < 18; n++) begin
			wr(wtab[n][47:40], wtab[n][39:24], wtab[n][16]);
			rd(wtab[n][47:40], 1'b0, wtab[n][15:0]);
		end
		wr(8'h79, 16'h0000, 1'b1);
		wr(8'h37, 16'he900, 1'b1);
		rd(8'h37, 1'b1, 16'h0000);
		rd(8'h79, 1'b0, 16'h0042);
		pulse_clear();
		rd(8'h79, 1'b0, 16'h0040);
		// overvoltage at the fault limit, then clear only the fault bit
		meas.vout = 16'hffff;
		tick(3);
		rd(8'h7a, 1'b0, 16'h00c0);
		rd(8'h79, 1'b0, 16'h8860);
		meas.vout = 16'h0000;
		wr(8'h7a, 16'h0080, 1'b0);
		rd(8'h7a, 1'b0, 16'h0040);
		meas.iout = 16'he230;
		tick(3);
		rd(8'h7b, 1'b0, 16'h00a0);
		meas.iout = 16'he000;
		wr(8'h7b, 16'h00ff, 1'b0);
		rd(8'h7b, 1'b0, 16'h0000);
		// start: 40 units of delay, 30 units of rise
		pulse_clear();
		enable_pin = 1'b1;
		for (n = 0; n < 400 && !output_on; n++) tick(1);
		check(18'(n >= 160 && n <= 168), 18'h00001);
		for (n = 0; n < 400 && ramp_active; n++) tick(1);
		check(18'(n), 18'(30 * TU));
		check(18'(output_on), 18'h00001);
		meas.vout = 16'hb000;
		tick(3);
		check(18'(output_good), 18'h00001);
		meas.vout = 16'h9001;
		tick(3);
		check(18'(output_good), 18'h00001);
		meas.vout = 16'h9000;
		tick(3);
		check(18'(output_good), 18'h00000);
		// input drops below turn-off while running, temperature at its warning limit
		meas.vin = 16'he900;
		meas.temp = 16'hf1e0;
		tick(3);
		check(18'(output_on), 18'h00000);
		rd(8'h79, 1'b0, 16'h204c);
		check({2'b00, status_word}, 18'h0204c);
		results();
	end
endmodule

bind cpl_limit_bank cpl_limit_bank_checker #(.TIME_UNIT_CYCLES(TIME_UNIT_CYCLES)) i_chk (
	.CORE_CLK(CORE_CLK), .RST_N(RST_N), .CMD(CMD), .CLEAR_STATUS(CLEAR_STATUS),
	.RSP_VALID(RSP_VALID), .RSP_ERR(RSP_ERR), .RSP_RDATA(RSP_RDATA), .MEAS(MEAS),
	.ENABLE_PIN(ENABLE_PIN), .OUTPUT_GOOD(OUTPUT_GOOD), .RAMP_ACTIVE(RAMP_ACTIVE),
	.OUTPUT_ON(OUTPUT_ON), .STATUS_WORD_OUT(STATUS_WORD_OUT));
